/* rtl/acc_conv_ctl.sv */
// Decided for this implementation: the address-and-strobe port.
module acc_conv_ctl #(
    parameter bit UNIT_IS_FIRST = 1'b1,
    parameter bit THIRD_UNIT    = 1'b0
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic [7:0]                addr_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    input  wire logic [6:0]                trig_src_i,
    input  wire logic [acc_pkg::RES_W-1:0] result_i,
    output logic      [31:0]               rdata_o,
    output logic                           power_on_o,
    output logic                           conv_busy_o,
    output logic                           cal_busy_o,
    output logic                           internal_ch_en_o,
    output logic                           dma_req_o,
    output logic      [15:0]               data_o,
    output logic                           data_valid_o
);
    // =====================================================================
    // State
    typedef struct packed {
        acc_pkg::acc_state_e fsm;
        logic [31:0]         ctl;
        logic                start_flag;
        logic                eoc_flag;
        logic [15:0]         cnt;
        logic [31:0]         rdata;
        logic                power;
        logic                busy;
        logic                cal_busy;
        logic                intch;
        logic                dma_req;
        logic [15:0]         data;
        logic                data_valid;
        logic                pend;
    } acc_cc_s;
    acc_cc_s st_reg;
    acc_cc_s st_next;

    acc_trig_if trig ();
    logic [15:0] aligned;

    acc_trig_sel #(
        .THIRD_UNIT (THIRD_UNIT)
    ) i_acc_trig_sel (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .trig_src_i (trig_src_i),
        .trig       (trig)
    );

    acc_align #(
        .RES_W (acc_pkg::RES_W)
    ) i_acc_align (
        .raw_i  (result_i),
        .msb_i  (st_reg.ctl[acc_pkg::BIT_ALIGN]),
        .word_o (aligned)
    );

    assign trig.sel    = st_reg.ctl[acc_pkg::TSEL_LSB +: 3];
    assign trig.enable = st_reg.ctl[acc_pkg::BIT_EXTEN] && st_reg.ctl[acc_pkg::BIT_ON];

    // =====================================================================
    // Decode helpers
    logic ctl_wr;
    logic stat_wr;
    logic [31:0] wval;
    logic on_rise;
    logic rewrite_on;
    logic sw_go;
    logic start_req;
    assign ctl_wr     = wr_i && addr_i == acc_pkg::CTL1_OFFSET;
    assign stat_wr    = wr_i && addr_i == acc_pkg::STAT_OFFSET;
    assign wval       = wdata_i & acc_pkg::CTL1_WR_MASK;
    assign on_rise    = ctl_wr && wval[acc_pkg::BIT_ON] && !st_reg.ctl[acc_pkg::BIT_ON];
    // A start needs the on bit rewritten with every other writable bit unchanged, calibration bits included
    assign rewrite_on = ctl_wr && st_reg.ctl[acc_pkg::BIT_ON] && wval[acc_pkg::BIT_ON]
                        && wval == st_reg.ctl;
    assign sw_go      = st_reg.ctl[acc_pkg::BIT_SWSTART]
                        && st_reg.ctl[acc_pkg::TSEL_LSB +: 3] == acc_pkg::TSEL_SOFTWARE;
    assign start_req  = sw_go || trig.fire || rewrite_on || st_reg.pend;

    // =====================================================================
    // Next state
    always_comb
    begin
        st_next            = st_reg;
        st_next.data_valid = 1'b0;
        st_next.dma_req    = 1'b0;
        st_next.rdata      = 32'h0000_0000;
        if (ctl_wr)
        begin
            // Keep the calibration and calibration-reset bits set until hardware drops them
            st_next.ctl = wval | (st_reg.ctl & (32'h1 << acc_pkg::BIT_CALRST))
                               | (st_reg.ctl & (32'h1 << acc_pkg::BIT_CAL));
        end
        // Status clears first, so a hardware set later in this cycle wins
        if (stat_wr)
        begin
            if (!wdata_i[acc_pkg::BIT_RSTART])
                st_next.start_flag = 1'b0;
            if (!wdata_i[acc_pkg::BIT_EOC])
                st_next.eoc_flag = 1'b0;
        end
        // Remember a start that lands while the converter is busy
        if ((trig.fire || rewrite_on) && st_reg.fsm != acc_pkg::ACC_IDLE)
            st_next.pend = st_reg.ctl[acc_pkg::BIT_ON];
        case (st_reg.fsm)
            acc_pkg::ACC_OFF:
            begin
                st_next.power = 1'b0;
                st_next.busy  = 1'b0;
                st_next.pend  = 1'b0;
                if (on_rise)
                begin
                    st_next.power = 1'b1;
                    st_next.cnt   = 16'(acc_pkg::STAB_CYCLES - 1);
                    st_next.fsm   = acc_pkg::ACC_STAB;
                end
            end
            acc_pkg::ACC_STAB:
            begin
                if (st_reg.cnt == 16'h0000)
                    st_next.fsm = acc_pkg::ACC_IDLE;
                else
                    st_next.cnt = st_reg.cnt - 16'h0001;
            end
            acc_pkg::ACC_IDLE:
            begin
                if (st_reg.ctl[acc_pkg::BIT_CALRST])
                begin
                    st_next.cal_busy = 1'b1;
                    st_next.cnt      = 16'(acc_pkg::CALRST_CYCLES - 1);
                    st_next.fsm      = acc_pkg::ACC_CALRST;
                end
                else if (st_reg.ctl[acc_pkg::BIT_CAL])
                begin
                    st_next.cal_busy = 1'b1;
                    st_next.cnt      = 16'(acc_pkg::CAL_CYCLES - 1);
                    st_next.fsm      = acc_pkg::ACC_CAL;
                end
                else if (start_req)
                begin
                    st_next.busy       = 1'b1;
                    st_next.pend       = 1'b0;
                    st_next.start_flag = 1'b1;
                    st_next.cnt        = 16'(acc_pkg::CONV_CYCLES - 1);
                    st_next.fsm        = acc_pkg::ACC_CONV;
                    if (sw_go)
                        st_next.ctl[acc_pkg::BIT_SWSTART] = 1'b0;
                end
            end
            acc_pkg::ACC_CALRST:
            begin
                if (st_reg.cnt == 16'h0000)
                begin
                    st_next.ctl[acc_pkg::BIT_CALRST] = 1'b0;
                    st_next.cal_busy = 1'b0;
                    st_next.fsm      = acc_pkg::ACC_IDLE;
                end
                else
                    st_next.cnt = st_reg.cnt - 16'h0001;
            end
            acc_pkg::ACC_CAL:
            begin
                if (st_reg.cnt == 16'h0000)
                begin
                    st_next.ctl[acc_pkg::BIT_CAL] = 1'b0;
                    st_next.cal_busy = 1'b0;
                    st_next.fsm      = acc_pkg::ACC_IDLE;
                end
                else
                    st_next.cnt = st_reg.cnt - 16'h0001;
            end
            acc_pkg::ACC_CONV:
            begin
                if (st_reg.cnt == 16'h0000)
                begin
                    st_next.data       = aligned;
                    st_next.data_valid = 1'b1;
                    st_next.eoc_flag   = 1'b1;
                    st_next.dma_req    = st_reg.ctl[acc_pkg::BIT_DMA];
                    if (st_reg.ctl[acc_pkg::BIT_CONT])
                    begin
                        // Restart at once; software stops it by clearing the bit
                        st_next.start_flag = 1'b1;
                        st_next.cnt        = 16'(acc_pkg::CONV_CYCLES - 1);
                    end
                    else
                    begin
                        st_next.busy = 1'b0;
                        st_next.fsm  = acc_pkg::ACC_IDLE;
                    end
                end
                else
                    st_next.cnt = st_reg.cnt - 16'h0001;
            end
            default:
                st_next.fsm = acc_pkg::ACC_OFF;
        endcase
        // Power-down overrides the state, power, busy and calibration bits; a result ending this cycle is still delivered
        if (ctl_wr && !wval[acc_pkg::BIT_ON])
        begin
            st_next.fsm      = acc_pkg::ACC_OFF;
            st_next.power    = 1'b0;
            st_next.busy     = 1'b0;
            st_next.cal_busy = 1'b0;
            st_next.ctl[acc_pkg::BIT_CAL]    = 1'b0;
            st_next.ctl[acc_pkg::BIT_CALRST] = 1'b0;
        end
        st_next.intch = UNIT_IS_FIRST && st_next.ctl[acc_pkg::BIT_INTCH];
        if (rd_i)
        begin
            if (addr_i == acc_pkg::CTL1_OFFSET)
                st_next.rdata = st_reg.ctl;
            else if (addr_i == acc_pkg::STAT_OFFSET)
                st_next.rdata = {27'h0, st_reg.start_flag, 2'h0, st_reg.eoc_flag, 1'b0};
        end
    end

    // =====================================================================
    // Registers
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_reg     <= '0;
            st_reg.ctl <= acc_pkg::CTL1_RESET;
            st_reg.fsm <= acc_pkg::ACC_OFF;
        end
        else
            st_reg <= st_next;
    end

    assign rdata_o          = st_reg.rdata;
    assign power_on_o       = st_reg.power;
    assign conv_busy_o      = st_reg.busy;
    assign cal_busy_o       = st_reg.cal_busy;
    assign internal_ch_en_o = st_reg.intch;
    assign dma_req_o        = st_reg.dma_req;
    assign data_o           = st_reg.data;
    assign data_valid_o     = st_reg.data_valid;

    // =====================================================================
    // Checks
    property p_off_dark;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !st_reg.ctl[acc_pkg::BIT_ON] |-> !power_on_o && !conv_busy_o;
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("powered while off");

    property p_stab;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(power_on_o) |-> !conv_busy_o [*2];
    endproperty
    a_stab: assert property (p_stab) else $error("converted during stabilization");

    property p_dma_gate;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        dma_req_o |-> $past(st_reg.ctl[acc_pkg::BIT_DMA]) && data_valid_o;
    endproperty
    a_dma_gate: assert property (p_dma_gate) else $error("dma without enable");

    property p_sw_clear;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        st_reg.fsm == acc_pkg::ACC_IDLE && sw_go && !st_reg.ctl[acc_pkg::BIT_CALRST]
        && !st_reg.ctl[acc_pkg::BIT_CAL] && !ctl_wr
        |=> !st_reg.ctl[acc_pkg::BIT_SWSTART] && st_reg.start_flag && conv_busy_o;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("software start not taken");

    property p_sw_needs_sel;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(conv_busy_o) && $past(st_reg.ctl[acc_pkg::BIT_SWSTART])
        && !$past(trig.fire) && !$past(st_reg.pend) && !$past(rewrite_on)
        |-> $past(st_reg.ctl[acc_pkg::TSEL_LSB +: 3]) == acc_pkg::TSEL_SOFTWARE;
    endproperty
    a_sw_needs_sel: assert property (p_sw_needs_sel) else $error("bad software start");

    property p_ext_gate;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        trig.fire |-> $past(st_reg.ctl[acc_pkg::BIT_EXTEN]);
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("trigger while disabled");

    property p_flag_on_start;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(conv_busy_o) |-> st_reg.start_flag;
    endproperty
    a_flag_on_start: assert property (p_flag_on_start) else $error("no start flag");

    property p_calrst_done;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        st_reg.fsm == acc_pkg::ACC_CALRST && st_reg.cnt == 16'h0000 && !ctl_wr
        |=> !st_reg.ctl[acc_pkg::BIT_CALRST] && !cal_busy_o;
    endproperty
    a_calrst_done: assert property (p_calrst_done) else $error("cal reset stuck");

    property p_cal_done;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        st_reg.fsm == acc_pkg::ACC_CAL && st_reg.cnt == 16'h0000 && !ctl_wr
        |=> !st_reg.ctl[acc_pkg::BIT_CAL];
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("calibration stuck");

    property p_cont;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        data_valid_o && $past(st_reg.ctl[acc_pkg::BIT_CONT]) && !$past(ctl_wr) |-> conv_busy_o;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous mode stopped");

    c_sw_conv: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        sw_go ##1 conv_busy_o);
    c_ext_conv: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) trig.fire);
    c_dma: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) dma_req_o);
    c_cal: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $fell(cal_busy_o));
endmodule : acc_conv_ctl

/* include/acc_pkg.sv */
package acc_pkg;
    // =====================================================================
    // Register map
    localparam logic [7:0]  CTL1_OFFSET     = 8'h08;
    localparam logic [7:0]  STAT_OFFSET     = 8'h00;
    localparam logic [31:0] CTL1_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTL1_WR_MASK    = 32'h00DE_090F;
    // =====================================================================
    // Control field positions
    localparam int BIT_ON       = 0;
    localparam int BIT_CONT     = 1;
    localparam int BIT_CAL      = 2;
    localparam int BIT_CALRST   = 3;
    localparam int BIT_DMA      = 8;
    localparam int BIT_ALIGN    = 11;
    localparam int TSEL_LSB     = 17;
    localparam int BIT_EXTEN    = 20;
    localparam int BIT_SWSTART  = 22;
    localparam int BIT_INTCH    = 23;
    // Status field positions
    localparam int BIT_RSTART   = 4;
    localparam int BIT_EOC      = 1;
    // =====================================================================
    // Trigger codes and timing
    localparam logic [2:0] TSEL_SOFTWARE = 3'h7;
    localparam int CLK_MHZ          = 40;
    localparam int STAB_NS          = 1000;
    localparam int STAB_CYCLES      = (STAB_NS * CLK_MHZ + 999) / 1000;
    localparam int CALRST_CYCLES    = 4;
    localparam int CAL_CYCLES       = 16;
    localparam int CONV_CYCLES      = 14;
    localparam int RES_W            = 12;
    // =====================================================================
    typedef enum logic [2:0] {ACC_OFF, ACC_STAB, ACC_IDLE, ACC_CALRST, ACC_CAL, ACC_CONV}
        acc_state_e;
endpackage : acc_pkg

/* include/acc_trig_if.sv */
// =========================================================================
// Trigger request path between the selector and the sequencer
interface acc_trig_if;
    logic       fire;
    logic [2:0] sel;
    logic       enable;
    modport src (output fire, input sel, input enable);
    modport dst (input fire, output sel, output enable);
endinterface : acc_trig_if

/* rtl/acc_trig_sel.sv */
// =========================================================================
// Routine trigger selector: rising edge of the chosen source
module acc_trig_sel #(
    parameter bit THIRD_UNIT = 1'b0
) (
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [6:0] trig_src_i,
    acc_trig_if.src         trig
);
    typedef struct packed {
        logic [6:0] prev;
        logic       fire;
    } acc_ts_s;
    acc_ts_s st_reg;
    acc_ts_s st_next;

    // Sources are the same for every unit; code 7 is software and never fires here
    always_comb
    begin
        st_next      = st_reg;
        st_next.prev = trig_src_i;
        st_next.fire = 1'b0;
        if (trig.enable && trig.sel != acc_pkg::TSEL_SOFTWARE)
            st_next.fire = trig_src_i[trig.sel] & ~st_reg.prev[trig.sel];
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign trig.fire = st_reg.fire;
endmodule : acc_trig_sel

/* rtl/acc_align.sv */
// =========================================================================
// Result alignment into a 16-bit data word
module acc_align #(
    parameter int RES_W = 12
) (
    input  wire logic [RES_W-1:0] raw_i,
    input  wire logic             msb_i,
    output logic      [15:0]      word_o
);
    // Left shift fills the low end with zeros
    always_comb
    begin
        if (msb_i)
            word_o = {raw_i, {(16 - RES_W){1'b0}}};
        else
            word_o = {{(16 - RES_W){1'b0}}, raw_i};
    end
endmodule : acc_align

/* verif/acc_trig_model.sv */
// =========================================================================
// Timer channels and external line feeding the routine trigger inputs
module acc_trig_model (
    input  wire logic       core_clk_i,
    input  wire logic       fire_i,
    input  wire logic [2:0] code_i,
    input  wire logic [3:0] hold_i,
    output logic      [6:0] trig_src_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] hold_cnt = 4'h0;
    logic [2:0] line_sel = 3'h0;

    // =====================================================================
    // One source pulses high for hold_i cycles, so fast and slow edges occur
    always @(posedge core_clk_i)
    begin
        if (fire_i)
        begin
            hold_cnt <= (hold_i == 4'h0) ? 4'h1 : hold_i;
            line_sel <= code_i;
        end
        else if (hold_cnt != 4'h0)
            hold_cnt <= hold_cnt - 4'h1;
    end

    // Idle level low; only the chosen line moves
    assign trig_src_o = (hold_cnt != 4'h0) ? (7'h01 << line_sel) : 7'h00;
endmodule : acc_trig_model

/* verif/acc_conv_ctl_test.sv */
// =========================================================================
// Self-checking bench for the converter control block
module acc_conv_ctl_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk_i = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic [7:0]  addr_i     = 8'h00;
    logic [31:0] wdata_i    = 32'h0000_0000;
    logic        wr_i       = 1'b0;
    logic        rd_i       = 1'b0;
    logic [6:0]  trig_src;
    logic [11:0] result_i   = 12'h000;
    logic [31:0] rdata_o;
    logic        power_on_o, conv_busy_o, cal_busy_o, internal_ch_en_o;
    logic        dma_req_o, data_valid_o;
    logic [15:0] data_o;
    logic        fire       = 1'b0;
    logic [2:0]  code       = 3'h0;
    logic [3:0]  hold       = 4'h1;
    int          err_total  = 0;
    int          checks     = 0;
    logic [31:0] q, c;

    always #12.5 core_clk_i = ~core_clk_i;

    acc_conv_ctl i_acc_conv_ctl (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .trig_src_i(trig_src), .result_i(result_i),
        .rdata_o(rdata_o), .power_on_o(power_on_o), .conv_busy_o(conv_busy_o),
        .cal_busy_o(cal_busy_o), .internal_ch_en_o(internal_ch_en_o),
        .dma_req_o(dma_req_o), .data_o(data_o), .data_valid_o(data_valid_o));

    acc_trig_model i_acc_trig_model (
        .core_clk_i(core_clk_i), .fire_i(fire), .code_i(code), .hold_i(hold),
        .trig_src_o(trig_src));

    // =====================================================================
    // Compare and verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task results;
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // =====================================================================
    // Register port: full word accesses only, reserved bits kept zero
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // Expected word: low or high justified 12-bit result
    function automatic logic [15:0] aligned(input logic [11:0] r, input logic msb);
        return msb ? {r, 4'h0} : {4'h0, r};
    endfunction : aligned

    // Bounded wait for a conversion end; checks data and request when seen
    task expect_conv(input logic want, input logic [31:0] ctl);
        logic got;
        got = 1'b0;
        for (int i = 0; i < 40 && !got; i++)
        begin
            @(posedge core_clk_i);
            #1 got = (data_valid_o === 1'b1);
        end
        chk(got, want);
        if (got)
        begin
            chk(data_o, aligned(result_i, ctl[11]));
            chk(dma_req_o, ctl[8]);
        end
    endtask : expect_conv

    task pulse(input logic [2:0] k);
        @(posedge core_clk_i);
        code <= k;
        hold <= 4'($urandom_range(1, 6));
        fire <= 1'b1;
        @(posedge core_clk_i);
        fire <= 1'b0;
    endtask : pulse

    task settle;
        for (int i = 0; i < 60 && (conv_busy_o !== 1'b0 || cal_busy_o !== 1'b0); i++)
            @(posedge core_clk_i);
        repeat (2) @(posedge core_clk_i);
    endtask : settle

    // =====================================================================
    // Hang guard, reckoned well above the expected run length
    initial
    begin
        #(25ns * 20000);
        err_total++;
        results;
    end

    // =====================================================================
    // Main sequence
    initial
    begin
        void'($urandom(27278));
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd(acc_pkg::CTL1_OFFSET, q);
        chk(q, acc_pkg::CTL1_RESET);
        chk(power_on_o, 1'b0);
        rd(8'h40, q);
        chk(q, 32'h0000_0000);
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0001);
        @(posedge core_clk_i);
        #1 chk(power_on_o, 1'b1);
        repeat (acc_pkg::STAB_CYCLES + 4) @(posedge core_clk_i);
        // Random software starts with random alignment and request enable
        for (int n = 0; n < 6; n++)
        begin
            c = 32'h000E_0001 | ($urandom & 32'h0000_0900);
            result_i <= 12'($urandom);
            wr(acc_pkg::CTL1_OFFSET, c | 32'h0040_0000);
            expect_conv(1'b1, c);
            rd(acc_pkg::CTL1_OFFSET, q);
            chk(q, c);
            rd(acc_pkg::STAT_OFFSET, q);
            chk(q[acc_pkg::BIT_RSTART], 1'b1);
            wr(acc_pkg::STAT_OFFSET, 32'h0000_0000);
        end
        // Flags cleared by software stay clear while idle
        rd(acc_pkg::STAT_OFFSET, q);
        chk(q, 32'h0000_0000);
        // Software start ignored with a timer source selected
        wr(acc_pkg::CTL1_OFFSET, 32'h0046_0001);
        expect_conv(1'b0, 32'h0);
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0001);
        settle;
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0001);
        expect_conv(1'b1, 32'h1);
        // Every external code: wrong line ignored, right line starts
        for (int k = 0; k < 7; k++)
        begin
            c = 32'h0010_0001 | (32'(k) << acc_pkg::TSEL_LSB);
            wr(acc_pkg::CTL1_OFFSET, c);
            pulse(3'((k + 1) % 7));
            expect_conv(1'b0, c);
            pulse(3'(k));
            expect_conv(1'b1, c);
            wr(acc_pkg::CTL1_OFFSET, c & 32'hFFEF_FFFF);
            pulse(3'(k));
            expect_conv(1'b0, c);
        end
        // Continuous mode repeats until cleared
        wr(acc_pkg::CTL1_OFFSET, 32'h004E_0003);
        expect_conv(1'b1, 32'h3);
        expect_conv(1'b1, 32'h3);
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0001);
        settle;
        chk(conv_busy_o, 1'b0);
        // Calibration and calibration reset clear themselves
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0005);
        @(posedge core_clk_i);
        #1 chk(cal_busy_o, 1'b1);
        settle;
        rd(acc_pkg::CTL1_OFFSET, q);
        chk(q, 32'h0000_0001);
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0009);
        @(posedge core_clk_i);
        #1 chk(cal_busy_o, 1'b1);
        settle;
        rd(acc_pkg::CTL1_OFFSET, q);
        chk(q, 32'h0000_0001);
        // Internal channels follow their enable
        wr(acc_pkg::CTL1_OFFSET, 32'h0080_0001);
        @(posedge core_clk_i);
        #1 chk(internal_ch_en_o, 1'b1);
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0001);
        @(posedge core_clk_i);
        #1 chk(internal_ch_en_o, 1'b0);
        // Power down from idle, then stays off
        wr(acc_pkg::CTL1_OFFSET, 32'h0000_0000);
        @(posedge core_clk_i);
        #1 chk(power_on_o, 1'b0);
        pulse(3'h0);
        expect_conv(1'b0, 32'h0);
        results;
    end
endmodule : acc_conv_ctl_test
